// ===== verilog/interrupt_flag_status_bank0.sv
// interrupt flag status bank with an AXI4-Lite register port
// assumes request strobes are synchronous to aclk; one write and one read in flight
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module interrupt_flag_status_bank0 (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // peripheral request strobes
  input  wire logic                         dma_ch_b_done_req,
  input  wire logic                         converter_done_req,
  input  wire logic                         serial_tx_req,
  input  wire logic                         serial_rx_req,
  input  wire logic                         spi_event_req,
  input  wire logic                         spi_fault_req,
  input  wire logic                         timer_c_req,
  input  wire logic                         timer_b_req,
  input  wire logic                         compare_out_b_req,
  input  wire logic                         capture_in_b_req,
  input  wire logic                         dma_ch_a_done_req,
  input  wire logic                         timer_a_req,
  input  wire logic                         compare_out_a_req,
  input  wire logic                         capture_in_a_req,
  input  wire logic                         external_irq_zero_req,
  // write address channel
  input  wire logic [flag_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         awvalid,
  output logic                              awready,
  // write data channel
  input  wire logic [flag_pkg::DATA_W-1:0]  wdata,
  input  wire logic [flag_pkg::STRB_W-1:0]  wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  // write response channel
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  // read address channel
  input  wire logic [flag_pkg::ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                   arprot,
  input  wire logic                         arvalid,
  output logic                              arready,
  // read data channel
  output logic [flag_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // interrupt line
  output logic                              irq
);

  flag_ctl_if ctl ();

  // request vector in register bit order
  logic [15:0] req;

  assign req[15]                           = 1'b0;
  assign req[flag_pkg::BIT_DMA_B_DONE]     = dma_ch_b_done_req;
  assign req[flag_pkg::BIT_CONV_DONE]      = converter_done_req;
  assign req[flag_pkg::BIT_SERIAL_TX]      = serial_tx_req;
  assign req[flag_pkg::BIT_SERIAL_RX]      = serial_rx_req;
  assign req[flag_pkg::BIT_SPI_EVENT]      = spi_event_req;
  assign req[flag_pkg::BIT_SPI_FAULT]      = spi_fault_req;
  assign req[flag_pkg::BIT_TIMER_C]        = timer_c_req;
  assign req[flag_pkg::BIT_TIMER_B]        = timer_b_req;
  assign req[flag_pkg::BIT_COMPARE_B]      = compare_out_b_req;
  assign req[flag_pkg::BIT_CAPTURE_B]      = capture_in_b_req;
  assign req[flag_pkg::BIT_DMA_A_DONE]     = dma_ch_a_done_req;
  assign req[flag_pkg::BIT_TIMER_A]        = timer_a_req;
  assign req[flag_pkg::BIT_COMPARE_A]      = compare_out_a_req;
  assign req[flag_pkg::BIT_CAPTURE_A]      = capture_in_a_req;
  assign req[flag_pkg::BIT_EXT_ZERO]       = external_irq_zero_req;

  // ---------------------------------------------------------------
  // write path: address and data are taken independently
  // ---------------------------------------------------------------

  logic                         aw_held;
  logic                         w_held;
  logic [flag_pkg::ADDR_W-1:0]  aw_addr;
  logic [flag_pkg::DATA_W-1:0]  w_data;
  logic [flag_pkg::STRB_W-1:0]  w_strb;

  // handshakes and hold bookkeeping
  wire aw_take        = awvalid & awready;
  wire w_take         = wvalid & wready;
  wire commit         = aw_held & w_held & ~bvalid;
  wire next_aw_held   = (aw_held & ~commit) | aw_take;
  wire next_w_held    = (w_held & ~commit) | w_take;
  wire b_done         = bvalid & bready;
  wire next_bvalid    = (bvalid & ~b_done) | commit;

  // address capture; protection bits carry no meaning here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else begin
      aw_held <= next_aw_held;
      if (aw_take) aw_addr <= awaddr;
    end
  end

  // data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      w_held <= next_w_held;
      if (w_take) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // readies drop while a beat is parked, so nothing is overwritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= ~next_aw_held;
      wready  <= ~next_w_held;
    end
  end

  // write decode on the parked address
  wire ws_flags   = (aw_addr == flag_pkg::OFF_FLAGS);
  wire ws_clear   = (aw_addr == flag_pkg::OFF_CLEAR);
  wire ws_enable  = (aw_addr == flag_pkg::OFF_ENABLE);
  wire ws_mapped  = ws_flags | ws_clear | ws_enable;

  // byte lanes 0 and 1 cover the 16 flag bits; upper lanes are ignored
  wire [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // flag register write: software may set or clear any implemented bit
  assign ctl.wr_en    = commit & ws_flags;
  assign ctl.wr_data  = w_data[15:0];
  assign ctl.wr_mask  = lane_mask;

  // clear register: ones clear, zeros leave the flag alone
  assign ctl.clr_en   = commit & ws_clear;
  assign ctl.clr_mask = w_data[15:0] & lane_mask;

  // enable register
  assign ctl.en_we    = commit & ws_enable;
  assign ctl.en_data  = w_data[15:0];
  assign ctl.en_mask  = lane_mask;

  // response: read-only and unmapped offsets answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= flag_pkg::RESP_OKAY;
    end else begin
      bvalid <= next_bvalid;
      if (commit) bresp <= ws_mapped ? flag_pkg::RESP_OKAY : flag_pkg::RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // read path: one cycle from address to data
  // ---------------------------------------------------------------

  wire ar_take      = arvalid & arready;
  wire r_done       = rvalid & rready;
  wire next_rvalid  = (rvalid & ~r_done) | ar_take;

  // read decode on the incoming address
  wire rs_flags     = (araddr == flag_pkg::OFF_FLAGS);
  wire rs_status    = (araddr == flag_pkg::OFF_STATUS);
  wire rs_clear     = (araddr == flag_pkg::OFF_CLEAR);
  wire rs_enable    = (araddr == flag_pkg::OFF_ENABLE);
  wire rs_pending   = (araddr == flag_pkg::OFF_PENDING);
  wire rs_mapped    = rs_flags | rs_status | rs_clear | rs_enable | rs_pending;

  // the unused top bit is forced low on every view
  wire [15:0] flag_view    = ctl.flags & flag_pkg::FLAG_IMPL_MASK;
  wire [15:0] pending_view = flag_view & ctl.enables;

  // read data select; the clear register reads as zero
  wire [15:0] rd_sel =
      ({16{rs_flags | rs_status}} & flag_view)
    | ({16{rs_enable}}            & ctl.enables)
    | ({16{rs_pending}}           & pending_view);

  wire [flag_pkg::DATA_W-1:0] next_rdata = {16'h0000, rd_sel};

  // data is captured at the address handshake and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= flag_pkg::RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      if (ar_take) begin
        rdata <= next_rdata;
        rresp <= rs_mapped ? flag_pkg::RESP_OKAY : flag_pkg::RESP_SLVERR;
      end
    end
  end

  // address ready stays low while a read answer is outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) arready <= 1'b0;
    else          arready <= ~next_rvalid;
  end

  // ---------------------------------------------------------------
  // flag storage and interrupt gating
  // ---------------------------------------------------------------

  // sticky flags with request-over-clear priority
  flag_bank u_flag_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (req),
    .ctl     (ctl.bank)
  );

  // enables and the registered level interrupt
  irq_gate u_irq_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl.gate),
    .irq     (irq)
  );

endmodule : interrupt_flag_status_bank0

// ===== verilog/flag_pkg.sv
// constants for the interrupt flag bank: register map, field layout, resets
// assumes a 32-bit AXI4-Lite register port and a 16-bit flag register
package flag_pkg;

  // bus widths
  localparam int          DATA_W = 32;
  localparam int          ADDR_W = 8;
  localparam int          STRB_W = DATA_W / 8;
  localparam int          FLAG_W = 16;

  // register byte offsets
  localparam logic [7:0]  OFF_FLAGS   = 8'h00;  // interrupt_flag_status_0, read/write
  localparam logic [7:0]  OFF_STATUS  = 8'h04;  // read-only view of the sticky flags
  localparam logic [7:0]  OFF_CLEAR   = 8'h08;  // write-one-to-clear, reads zero
  localparam logic [7:0]  OFF_ENABLE  = 8'h0c;  // interrupt enables
  localparam logic [7:0]  OFF_PENDING = 8'h10;  // flags and enables, read-only

  // flag bit positions
  localparam int          BIT_DMA_B_DONE  = 14;
  localparam int          BIT_CONV_DONE   = 13;
  localparam int          BIT_SERIAL_TX   = 12;
  localparam int          BIT_SERIAL_RX   = 11;
  localparam int          BIT_SPI_EVENT   = 10;
  localparam int          BIT_SPI_FAULT   = 9;
  localparam int          BIT_TIMER_C     = 8;
  localparam int          BIT_TIMER_B     = 7;
  localparam int          BIT_COMPARE_B   = 6;
  localparam int          BIT_CAPTURE_B   = 5;
  localparam int          BIT_DMA_A_DONE  = 4;
  localparam int          BIT_TIMER_A     = 3;
  localparam int          BIT_COMPARE_A   = 2;
  localparam int          BIT_CAPTURE_A   = 1;
  localparam int          BIT_EXT_ZERO    = 0;

  // implemented bits: the top bit is unused and reads zero
  localparam logic [15:0] FLAG_IMPL_MASK  = 16'h7fff;
  localparam logic [15:0] FLAG_RESET      = 16'h0000;
  localparam logic [15:0] ENABLE_RESET    = 16'h0000;

  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : flag_pkg

// ===== verilog/flag_ctl_if.sv
// control bundle between the register front end, the flag bank and the gate
// assumes all three sit on one clock
`timescale 1ns/1ps
interface flag_ctl_if;

  // software write into the flag register
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] wr_mask;
  // write-one-to-clear
  logic        clr_en;
  logic [15:0] clr_mask;
  // enable register write
  logic        en_we;
  logic [15:0] en_data;
  logic [15:0] en_mask;
  // state seen by software
  logic [15:0] flags;
  logic [15:0] enables;

  modport ctl  (output wr_en, wr_data, wr_mask, clr_en, clr_mask, en_we, en_data, en_mask,
                input  flags, enables);
  modport bank (input  wr_en, wr_data, wr_mask, clr_en, clr_mask, output flags);
  modport gate (input  en_we, en_data, en_mask, flags, output enables);

endinterface : flag_ctl_if

// ===== verilog/flag_bank.sv
// sticky interrupt request flags, one flip-flop per implemented bit
// assumes request strobes synchronous to aclk
`timescale 1ns/1ps
module flag_bank (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // request strobes from peripherals
  input  wire logic [15:0]          req,
  // register control
  flag_ctl_if.bank                  ctl
);

  wire [15:0] flag;

  // per-bit flag: a request in the same cycle beats any clear
  // each implemented bit keeps its own flip-flop so every vector bit has a single driver
  for (genvar i = 0; i < 16; i++) begin : g_flag
    if (flag_pkg::FLAG_IMPL_MASK[i]) begin : g_impl
      logic bit_q;
      logic next_flag;
      always_comb begin
        next_flag = bit_q;
        if (ctl.wr_en && ctl.wr_mask[i]) begin
          next_flag = ctl.wr_data[i];
        end else if (ctl.clr_en && ctl.clr_mask[i]) begin
          next_flag = 1'b0;
        end
        if (req[i]) begin
          next_flag = 1'b1;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) bit_q <= flag_pkg::FLAG_RESET[i];
        else          bit_q <= next_flag;
      end
      assign flag[i] = bit_q;
    end else begin : g_unused
      assign flag[i] = 1'b0;
    end
  end

  assign ctl.flags = flag;

endmodule : flag_bank

// ===== verilog/irq_gate.sv
// interrupt enable register and the level interrupt output
// assumes flags come from flag_bank on the same clock
`timescale 1ns/1ps
module irq_gate (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // register control
  flag_ctl_if.gate  ctl,
  // interrupt line
  output logic      irq
);

  logic [15:0] enable;
  logic [15:0] next_enable;

  // byte-masked enable update
  assign next_enable = ctl.en_we ? ((enable & ~ctl.en_mask) | (ctl.en_data & ctl.en_mask)) : enable;

  // registered level: one cycle behind the flag that raises it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= flag_pkg::ENABLE_RESET;
      irq    <= 1'b0;
    end else begin
      enable <= next_enable & flag_pkg::FLAG_IMPL_MASK;
      irq    <= |(ctl.flags & enable);
    end
  end

  assign ctl.enables = enable;

endmodule : irq_gate

// ===== bench/periph_model.sv
// peripheral side: one-cycle request strobes on command from the bench
// assumes the bench drives fire just after a rising edge
`timescale 1ns/1ps
module periph_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // command from the bench
  input  wire logic [14:0] fire,
  // request strobes toward the flag bank
  output logic      [14:0] req
);
  // registered so strobes leave just after an edge, as a real peripheral would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= 15'h0;
    end else begin
      req <= fire;
    end
  end
endmodule : periph_model

// ===== bench/flag_bank_chk.sv
// assertions on the register port and interrupt line of the flag bank
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module flag_bank_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  // read channels
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // interrupt line
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // transfer steps
  sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence rd_taken; arvalid && arready; endsequence

  chk_write_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write not answered");
  chk_read_answer: assert property (rd_taken |=> rvalid)
    else $error("read not answered");
  chk_bvalid_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  chk_rvalid_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed");
  chk_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  chk_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address accepted while busy");
  chk_top_zero: assert property (rvalid |-> rdata[31:15] == 17'h0)
    else $error("unused bits read nonzero");
  chk_reset_quiet: assert property (!$past(aresetn) |-> !bvalid && !rvalid && !irq)
    else $error("outputs active after reset");
endmodule : flag_bank_chk

bind interrupt_flag_status_bank0 flag_bank_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .irq(irq));

// ===== bench/interrupt_flag_status_bank0_tb.sv
// self-checking bench for the flag bank through its register port
// assumes periph_model and flag_bank_chk are compiled before it
`timescale 1ns/1ps
module interrupt_flag_status_bank0_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [14:0] fire = 15'h0;
  logic [14:0] req;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errors = 0;
  int          samples_checked = 0;

  // 100 MHz
  always #5 aclk = ~aclk;

  periph_model i_periph (.aclk(aclk), .aresetn(aresetn), .fire(fire), .req(req));

  interrupt_flag_status_bank0 i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .dma_ch_b_done_req(req[14]), .converter_done_req(req[13]), .serial_tx_req(req[12]),
    .serial_rx_req(req[11]), .spi_event_req(req[10]), .spi_fault_req(req[9]), .timer_c_req(req[8]),
    .timer_b_req(req[7]), .compare_out_b_req(req[6]), .capture_in_b_req(req[5]),
    .dma_ch_a_done_req(req[4]), .timer_a_req(req[3]), .compare_out_a_req(req[2]),
    .capture_in_a_req(req[1]), .external_irq_zero_req(req[0]),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // bready is up from the start, so the response is taken at the first edge it stands
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er = flag_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    if (n == 64) errors++;
    check({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = flag_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    if (n == 64) errors++;
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask : axi_rd

  // one strobe, then time for flag and irq to settle
  task automatic pulse(input logic [14:0] m);
    @(posedge aclk);
    fire <= m;
    @(posedge aclk);
    fire <= 15'h0;
    repeat (3) @(posedge aclk);
  endtask : pulse

  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) axi_rd(8'(i * 4), 32'h0);
    $display("test reset values done");
    // each source sets only its own bit and stays set until cleared
    for (int i = 0; i < 15; i++) begin
      pulse(15'(1 << i));
      axi_rd(flag_pkg::OFF_FLAGS, 32'(1 << i));
      axi_rd(flag_pkg::OFF_STATUS, 32'(1 << i));
      axi_wr(flag_pkg::OFF_CLEAR, 32'(1 << i), 4'hf);
      axi_rd(flag_pkg::OFF_FLAGS, 32'h0);
    end
    $display("test source mapping done");
    axi_wr(flag_pkg::OFF_FLAGS, 32'hffff_ffff, 4'h1);
    axi_rd(flag_pkg::OFF_FLAGS, 32'h0000_00ff);
    axi_wr(flag_pkg::OFF_FLAGS, 32'hffff_ffff, 4'hf);
    axi_rd(flag_pkg::OFF_FLAGS, 32'h0000_7fff);
    axi_wr(flag_pkg::OFF_FLAGS, 32'h0, 4'hf);
    axi_rd(flag_pkg::OFF_FLAGS, 32'h0);
    $display("test software access done");
    axi_wr(flag_pkg::OFF_ENABLE, 32'h1000, 4'hf);
    axi_rd(flag_pkg::OFF_ENABLE, 32'h1000);
    pulse(15'h0800);
    check({31'h0, irq}, 32'h0);
    pulse(15'h1000);
    check({31'h0, irq}, 32'h1);
    axi_rd(flag_pkg::OFF_PENDING, 32'h1000);
    axi_wr(flag_pkg::OFF_CLEAR, 32'h1800, 4'hf);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    // a reset in mid-run must drop set flags, enables and the line
    axi_wr(flag_pkg::OFF_ENABLE, 32'h0001, 4'hf);
    pulse(15'h0001);
    check({31'h0, irq}, 32'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(flag_pkg::OFF_FLAGS, 32'h0);
    axi_rd(flag_pkg::OFF_ENABLE, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test mid-run reset done");
    axi_rd(8'h20, 32'h0, flag_pkg::RESP_SLVERR);
    axi_wr(flag_pkg::OFF_STATUS, 32'h1, 4'hf, flag_pkg::RESP_SLVERR);
    axi_rd(flag_pkg::OFF_FLAGS, 32'h0);
    $display("test refused access done");
    results();
  end

  // watchdog: the tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end
endmodule : interrupt_flag_status_bank0_tb
